/* rtl/bsd_status.sv */
// Backplane status and byte-lane decode outputs toward the local board.
// Assumes bus pins arrive asynchronously; arbitration and card select come
// from logic on mclk. The bus clock is sampled, its falling edge is the sample edge.
`timescale 1ns/1ps
`include "bsd_defines.svh"
module bsd_status
    import bsd_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       bus_clk,
    input  wire logic       bus_reset_n,
    input  wire logic       bus_start_n,
    input  wire logic       bus_ack_n,
    input  wire logic [1:0] bus_tm_n,
    input  wire logic       inv_addr_bit_zero,
    input  wire logic       inv_addr_bit_one,
    input  wire logic       arb_won,
    input  wire logic       arb_lost,
    input  wire logic       card_selected,
    input  wire logic       master_hold_in,
    input  wire logic       slave_grant_in,
    output logic            byte_lane_strobe_0,
    output logic            byte_lane_strobe_1,
    output logic            byte_lane_strobe_2,
    output logic            byte_lane_strobe_3,
    output logic            master_transfer_done,
    output logic            ack_monitor_out,
    output logic            start_monitor_out,
    output logic            mode_monitor_out_0,
    output logic            mode_monitor_out_1,
    output logic            bus_clock_copy,
    output logic            bus_clock_copy_n,
    output logic            locked_slave_flag,
    output logic            synced_bus_reset,
    output logic            held_mode_out_0,
    output logic            held_mode_out_1,
    output logic            bus_owner_flag,
    output logic            slave_request_out
);

    logic [`BSD_SYNC_W-1:0] pins;
    logic [`BSD_SYNC_W-1:0] pins_s;
    logic [3:0]             dec_n;
    logic                   clk_s;
    logic                   rst_s;
    logic                   start_s;
    logic                   ack_s;
    logic [1:0]             tm_s;
    logic                   sample;
    logic                   start_cyc;
    logic                   ack_cyc;
    logic                   attn_cyc;
    logic                   done_set;
    logic                   owner_set;
    bsd_st_t                st;
    bsd_st_t                next_st;

    assign pins = {bus_clk, bus_reset_n, bus_start_n, bus_ack_n,
                   bus_tm_n, inv_addr_bit_one, inv_addr_bit_zero};

    // Every bus pin is asynchronous here, the reset among them
    bsd_sync u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .ce   (ce),
        .din  (pins),
        .dout (pins_s)
    );

    // Address pins are used as given: already inverted outside
    bsd_lane_decode u_dec (
        .mode0   (pins_s[`BSD_BIT_TM0]),
        .addr    (pins_s[`BSD_BIT_A1:`BSD_BIT_A0]),
        .lanes_n (dec_n)
    );

    assign clk_s   = pins_s[`BSD_BIT_CLK];
    assign rst_s   = pins_s[`BSD_BIT_RST];
    assign start_s = pins_s[`BSD_BIT_START];
    assign ack_s   = pins_s[`BSD_BIT_ACK];
    assign tm_s    = pins_s[`BSD_BIT_TM1:`BSD_BIT_TM0];

    // Falling edge of the sampled bus clock is the sample edge
    assign sample    = ce & st.clk_d & ~clk_s;
    assign start_cyc = sample & ~start_s & ack_s;
    assign ack_cyc   = sample & start_s & ~ack_s;
    assign attn_cyc  = sample & ~start_s & ~ack_s;
    assign done_set  = st.owner & ack_cyc;
    assign owner_set = sample & arb_won;

    always_comb begin
        next_st            = st;
        next_st.clk_d      = clk_s;
        next_st.rst_n      = rst_s;
        next_st.lanes_n    = dec_n;
        next_st.mon_ack    = ~ack_s;
        next_st.mon_start  = ~start_s;
        next_st.mon_tm     = ~tm_s;
        next_st.clk_copy   = clk_s;
        next_st.clk_copy_n = ~clk_s;

        if (sample) begin
            next_st.start_seen = start_cyc;
        end

        // Ownership: a win beats a loss on the same edge
        if (owner_set) begin
            next_st.owner = 1'b1;
        end else if (sample & arb_lost) begin
            next_st.owner = 1'b0;
        end

        // Set wins over the release by master hold
        if (done_set) begin
            next_st.done = 1'b1;
        end else if (master_hold_in) begin
            next_st.done = 1'b0;
        end

        // Slave grant is not needed to take a request, so an early grant is fine
        if (start_cyc & card_selected & ~st.owner) begin
            next_st.slave_act = 1'b1;
        end else if (ack_cyc) begin
            next_st.slave_act = 1'b0;
        end
        next_st.slave_req_n = ~next_st.slave_act;

        // Lock tenure runs from attention lock to any other attention cycle
        if (attn_cyc) begin
            next_st.lock_pend = (start_s == 1'b0) &&
                                (tm_s == `BSD_ATTN_LOCK_N);
        end

        if (sample & st.start_seen) begin
            next_st.locked = st.lock_pend & st.slave_act;
        end else if (ack_cyc | ~next_st.slave_act) begin
            next_st.locked = 1'b0;
        end
        if (next_st.owner) begin
            next_st.locked = 1'b0;
        end

        // Second latch: code at start, status at acknowledge when owner
        if (start_cyc) begin
            next_st.held_tm = ~tm_s;
        end else if (ack_cyc & st.owner) begin
            next_st.held_tm = ~tm_s;
        end

        if (!rst_s) begin
            next_st.owner       = 1'b0;
            next_st.done        = 1'b0;
            next_st.slave_act   = 1'b0;
            next_st.slave_req_n = 1'b1;
            next_st.lock_pend   = 1'b0;
            next_st.locked      = 1'b0;
            next_st.start_seen  = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st             <= '0;
            st.clk_d       <= 1'b1;
            st.slave_req_n <= 1'b1;
            st.lanes_n     <= `BSD_LANES_IDLE;
            st.held_tm     <= `BSD_HELD_RESET;
            st.clk_copy    <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Mode line one is passed out and enters the attention lock compare; low marks write, high read
    assign byte_lane_strobe_0   = st.lanes_n[0];
    assign byte_lane_strobe_1   = st.lanes_n[1];
    assign byte_lane_strobe_2   = st.lanes_n[2];
    assign byte_lane_strobe_3   = st.lanes_n[3];
    assign master_transfer_done = st.done;
    assign ack_monitor_out      = st.mon_ack;
    assign start_monitor_out    = st.mon_start;
    assign mode_monitor_out_0   = st.mon_tm[0];
    assign mode_monitor_out_1   = st.mon_tm[1];
    assign bus_clock_copy       = st.clk_copy;
    assign bus_clock_copy_n     = st.clk_copy_n;
    assign locked_slave_flag    = st.locked;
    assign synced_bus_reset     = st.rst_n;
    assign held_mode_out_0      = st.held_tm[0];
    assign held_mode_out_1      = st.held_tm[1];
    assign bus_owner_flag       = st.owner;
    assign slave_request_out    = st.slave_req_n;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic [3:0] lanes_v;
    assign lanes_v = {byte_lane_strobe_3, byte_lane_strobe_2,
                      byte_lane_strobe_1, byte_lane_strobe_0};

    sequence s_ack_owned;
        ce && done_set && rst_s;
    endsequence

    sequence s_held_done;
        master_transfer_done && !master_hold_in && ce;
    endsequence

    property p_lane_byte;
        (ce && !pins_s[`BSD_BIT_TM0] && pins_s[1:0] == 2'h2) |=> lanes_v == 4'hB;
    endproperty
    a_lane_byte: assert property (p_lane_byte) else $error("byte strobe wrong");

    property p_lane_half;
        (ce && pins_s[`BSD_BIT_TM0] && pins_s[1:0] == 2'h3) |=> lanes_v == 4'h3;
    endproperty
    a_lane_half: assert property (p_lane_half) else $error("half strobe wrong");

    property p_lane_tm1;
        (ce && $stable({pins_s[`BSD_BIT_TM0], pins_s[1:0]}) && $past(ce) && $past(rstn))
            |=> $stable(lanes_v);
    endproperty
    a_lane_tm1: assert property (p_lane_tm1) else $error("strobes moved");

    property p_done_set;
        s_ack_owned |=> master_transfer_done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done missed");

    property p_done_hold;
        s_held_done ##1 rst_s |-> master_transfer_done;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done dropped");

    property p_monitor;
        ce |=> ack_monitor_out == !$past(ack_s) && start_monitor_out == !$past(start_s);
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor wrong");

    property p_clk_copy;
        bus_clock_copy != bus_clock_copy_n;
    endproperty
    a_clk_copy: assert property (p_clk_copy) else $error("clock copies equal");

    property p_lock_rise;
        $rose(locked_slave_flag) |-> $past(sample) && $past(st.start_seen);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock timing");

    property p_lock_master;
        bus_owner_flag |-> !locked_slave_flag;
    endproperty
    a_lock_master: assert property (p_lock_master) else $error("lock as master");

    property p_owner_rise;
        $rose(bus_owner_flag) |-> $past(owner_set);
    endproperty
    a_owner_rise: assert property (p_owner_rise) else $error("owner rise");

    property p_owner_hold;
        (bus_owner_flag && !(sample && arb_lost) && rst_s) |=> bus_owner_flag;
    endproperty
    a_owner_hold: assert property (p_owner_hold) else $error("owner dropped");

    property p_held_start;
        start_cyc |=> {held_mode_out_1, held_mode_out_0} == ~$past(tm_s);
    endproperty
    a_held_start: assert property (p_held_start) else $error("code not held");

    property p_reset_quiet;
        (ce && !rst_s) |=> !master_transfer_done && !bus_owner_flag
                           && !locked_slave_flag && slave_request_out && !synced_bus_reset;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset leak");

    sequence s_lock_armed;
        sample && st.start_seen && st.lock_pend && st.slave_act;
    endsequence

    property p_lock_set;
        s_lock_armed ##0 (!st.owner && !arb_won && rst_s) |=> locked_slave_flag;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock missed");

    property p_done_rise;
        $rose(master_transfer_done) |-> $past(done_set);
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("done without ack");

    property p_mode_mon;
        ce |=> {mode_monitor_out_1, mode_monitor_out_0} == ~$past(tm_s);
    endproperty
    a_mode_mon: assert property (p_mode_mon) else $error("mode monitor wrong");

    property p_clk_follow;
        ce |=> bus_clock_copy == $past(clk_s);
    endproperty
    a_clk_follow: assert property (p_clk_follow) else $error("clock copy wrong");

    property p_sync_reset;
        ce |=> synced_bus_reset == $past(rst_s);
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("reset copy wrong");

    property p_held_keep;
        (ce && !start_cyc && !(ack_cyc && st.owner)) |=> $stable({held_mode_out_1, held_mode_out_0});
    endproperty
    a_held_keep: assert property (p_held_keep) else $error("held code moved");

    property p_held_status;
        (ack_cyc && st.owner) |=> {held_mode_out_1, held_mode_out_0} == ~$past(tm_s);
    endproperty
    a_held_status: assert property (p_held_status) else $error("status not held");

    property p_req_set;
        (start_cyc && card_selected && !st.owner && rst_s) |=> !slave_request_out;
    endproperty
    a_req_set: assert property (p_req_set) else $error("request missed");

    property p_req_clear;
        ack_cyc |=> slave_request_out;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request stuck");

endmodule : bsd_status

/* rtl/bsd_defines.svh */
// Constants of the backplane status and byte-lane decode block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BSD_DEFINES_SVH
`define BSD_DEFINES_SVH

`define BSD_SYNC_W        8
// Sync vector: clk, reset_n, start_n, ack_n, tm1_n, tm0_n, a1, a0
`define BSD_SYNC_INIT     8'hBF
`define BSD_BIT_CLK       7
`define BSD_BIT_RST       6
`define BSD_BIT_START     5
`define BSD_BIT_ACK       4
`define BSD_BIT_TM1       3
`define BSD_BIT_TM0       2
`define BSD_BIT_A1        1
`define BSD_BIT_A0        0
// Active-low bus code {tm1_n, tm0_n} of an attention lock cycle
`define BSD_ATTN_LOCK_N   2'h2
`define BSD_LANES_IDLE    4'hF
`define BSD_HELD_RESET    2'h0

`endif

/* rtl/bsd_pkg.sv */
// Types of the backplane status and byte-lane decode block.
// Assumes bsd_defines.svh is available on the include path.
package bsd_pkg;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] q;
    } bsd_sync_st_t;

    typedef struct packed {
        logic       clk_d;
        logic       start_seen;
        logic       owner;
        logic       done;
        logic       slave_act;
        logic       slave_req_n;
        logic       lock_pend;
        logic       locked;
        logic       rst_n;
        logic [3:0] lanes_n;
        logic       mon_ack;
        logic       mon_start;
        logic [1:0] mon_tm;
        logic [1:0] held_tm;
        logic       clk_copy;
        logic       clk_copy_n;
    } bsd_st_t;

endpackage : bsd_pkg

/* rtl/bsd_sync.sv */
// Three-flop input synchroniser with agreement filter for backplane pins.
// Assumes inputs asynchronous to mclk; output moves when stages two and three agree.
`timescale 1ns/1ps
`include "bsd_defines.svh"
module bsd_sync
    import bsd_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   ce,
    input  wire logic [`BSD_SYNC_W-1:0] din,
    output logic      [`BSD_SYNC_W-1:0] dout
);

    bsd_sync_st_t st;
    bsd_sync_st_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Per bit: take the value once two clean stages agree
        next_st.q  = (st.s2 & st.s3) | (st.q & (st.s2 | st.s3));
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st <= {4{`BSD_SYNC_INIT}};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign dout = st.q;

endmodule : bsd_sync

/* rtl/bsd_lane_decode.sv */
// Byte-lane strobe decode from the two low address pins and mode line zero.
// Assumes pin levels already synchronised; purely combinational.
`timescale 1ns/1ps
`include "bsd_defines.svh"
module bsd_lane_decode
    import bsd_pkg::*;
(
    input  wire logic       mode0,
    input  wire logic [1:0] addr,
    output logic      [3:0] lanes_n
);

    // Mode line one never reaches this decode
    always_comb begin
        case ({mode0, addr})
            3'h0:    lanes_n = 4'hE;
            3'h1:    lanes_n = 4'hD;
            3'h2:    lanes_n = 4'hB;
            3'h3:    lanes_n = 4'h7;
            3'h4:    lanes_n = 4'h0;
            3'h5:    lanes_n = 4'hC;
            3'h6:    lanes_n = 4'h0;
            3'h7:    lanes_n = 4'h3;
            default: lanes_n = `BSD_LANES_IDLE;
        endcase
    end

endmodule : bsd_lane_decode

/* test/bsd_board_model.sv */
// Local board model facing the status outputs of the block.
// Assumes mclk domain; answers slave requests and releases master hold after a fixed use time.
`timescale 1ns/1ps
module bsd_board_model #(
    parameter int HOLD_CYC = 16
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic slave_request_out,
    input  wire logic master_transfer_done,
    input  wire logic bus_owner_flag,
    input  wire logic early_grant,
    output logic      master_hold_in,
    output logic      slave_grant_in
);
    logic [4:0] use_cnt;
    logic [1:0] req_d;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            use_cnt        <= 5'h00;
            req_d          <= 2'h3;
            master_hold_in <= 1'b1;
            slave_grant_in <= 1'b1;
        end else begin
            req_d          <= {req_d[0], slave_request_out};
            // Grant lags request so the block never sees a same-edge answer
            // A slave-only board may keep grant low ahead of the cycle
            slave_grant_in <= early_grant ? 1'b0 : req_d[1];
            use_cnt        <= master_transfer_done ? use_cnt + 5'h01 : 5'h00;
            // Hold stays active while the result is still in use
            master_hold_in <= !(bus_owner_flag && (use_cnt < 5'(HOLD_CYC)));
        end
    end
endmodule : bsd_board_model

/* test/backplane_status_byte_decode_bench.sv */
// Self-checking bench of the status and byte-lane decode block.
// Assumes 100 MHz mclk; bus pins driven as slow async levels, 5-edge sync latency.
`timescale 1ns/1ps
module backplane_status_byte_decode_bench;
    import bsd_pkg::*;
    logic       mclk, rstn, ce, bus_clk, bus_reset_n, bus_start_n, bus_ack_n;
    logic [1:0] bus_tm_n;
    logic       inv_addr_bit_zero, inv_addr_bit_one, arb_won, arb_lost, card_selected;
    logic       master_hold_in, slave_grant_in, early_grant;
    logic       s0, s1, s2, s3, done, ack_m, start_m, mode0, mode1, ck, ck_n;
    logic       locked, srst, held0, held1, owner, sreq;
    int         errors, checks_done, cycles;

    bsd_status bsd_status_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .bus_clk(bus_clk),
        .bus_reset_n(bus_reset_n), .bus_start_n(bus_start_n), .bus_ack_n(bus_ack_n),
        .bus_tm_n(bus_tm_n), .inv_addr_bit_zero(inv_addr_bit_zero),
        .inv_addr_bit_one(inv_addr_bit_one), .arb_won(arb_won), .arb_lost(arb_lost),
        .card_selected(card_selected), .master_hold_in(master_hold_in),
        .slave_grant_in(slave_grant_in), .byte_lane_strobe_0(s0), .byte_lane_strobe_1(s1),
        .byte_lane_strobe_2(s2), .byte_lane_strobe_3(s3), .master_transfer_done(done),
        .ack_monitor_out(ack_m), .start_monitor_out(start_m), .mode_monitor_out_0(mode0),
        .mode_monitor_out_1(mode1), .bus_clock_copy(ck), .bus_clock_copy_n(ck_n),
        .locked_slave_flag(locked), .synced_bus_reset(srst), .held_mode_out_0(held0),
        .held_mode_out_1(held1), .bus_owner_flag(owner), .slave_request_out(sreq));

    bsd_board_model bsd_board_model_inst (.mclk(mclk), .rstn(rstn),
        .slave_request_out(sreq), .master_transfer_done(done), .bus_owner_flag(owner),
        .master_hold_in(master_hold_in), .slave_grant_in(slave_grant_in),
        .early_grant(early_grant));

    always #5 mclk = ~mclk;

    task automatic complete_run;
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask : wait_n

    // One bus clock period; pins settle in the high phase, sampled after the fall
    task automatic bcyc(input logic st, input logic ak, input logic [1:0] tm);
        bus_start_n = st;
        bus_ack_n   = ak;
        bus_tm_n    = tm;
        bus_clk     = 1'b1;
        wait_n(4);
        bus_clk     = 1'b0;
        wait_n(7);
    endtask : bcyc

    function automatic logic [3:0] lanes(input logic m, input logic [1:0] a);
        if (!m)
            return ~(4'h1 << a);
        case (a)
            2'h1:    return 4'hC;
            2'h3:    return 4'h3;
            default: return 4'h0;
        endcase
    endfunction : lanes

    // All strobe codes with both read and write; monitors and clock copies alongside
    task automatic scen_decode;
        logic [4:0] i;
        for (i = 5'h00; i < 5'h10; i++) begin
            {bus_tm_n, inv_addr_bit_one, inv_addr_bit_zero} = i[3:0];
            bus_ack_n   = i[2];
            bus_start_n = i[1];
            bus_clk     = i[0];
            wait_n(8);
            chk({s3, s2, s1, s0, 4'h0}, {lanes(i[2], i[1:0]), 4'h0});
            chk({4'h0, ack_m, start_m, mode1, mode0}, {4'h0, ~i[2], ~i[1], ~i[3:2]});
            chk({6'h00, ck, ck_n}, {6'h00, i[0], ~i[0]});
        end
    endtask : scen_decode

    task automatic scen_master;
        arb_won = 1'b1;
        bcyc(1'b1, 1'b1, 2'h3);
        arb_won = 1'b0;
        chk({7'h00, owner}, 8'h01);
        bcyc(1'b0, 1'b0, 2'h2);
        card_selected = 1'b1;
        bcyc(1'b0, 1'b1, 2'h1);
        card_selected = 1'b0;
        chk({6'h00, held1, held0}, 8'h02);
        bcyc(1'b1, 1'b1, 2'h3);
        chk({5'h00, locked, held1, held0}, 8'h02);
        chk({7'h00, sreq}, 8'h01);
        bcyc(1'b1, 1'b0, 2'h2);
        chk({6'h00, done, held0}, 8'h03);
        wait_n(12);
        chk({7'h00, done}, 8'h01);
        wait_n(8);
        chk({5'h00, done, held1, held0}, 8'h01);
        chk({7'h00, owner}, 8'h01);
        arb_lost = 1'b1;
        bcyc(1'b1, 1'b1, 2'h3);
        arb_lost = 1'b0;
        chk({7'h00, owner}, 8'h00);
    endtask : scen_master

    task automatic scen_slave;
        early_grant = 1'b1;
        bcyc(1'b0, 1'b0, 2'h2);
        card_selected = 1'b1;
        bcyc(1'b0, 1'b1, 2'h0);
        card_selected = 1'b0;
        chk({6'h00, locked, sreq}, 8'h00);
        chk({6'h00, held1, held0}, 8'h03);
        bcyc(1'b1, 1'b1, 2'h3);
        chk({7'h00, locked}, 8'h01);
        bcyc(1'b1, 1'b0, 2'h1);
        chk({5'h00, locked, held1, held0}, 8'h03);
        chk({7'h00, sreq}, 8'h01);
        early_grant = 1'b0;
    endtask : scen_slave

    task automatic scen_bus_reset;
        arb_won = 1'b1;
        bcyc(1'b1, 1'b1, 2'h3);
        arb_won = 1'b0;
        bus_reset_n = 1'b0;
        wait_n(8);
        chk({5'h00, srst, owner, done}, 8'h00);
        chk({6'h00, locked, sreq}, 8'h01);
        bus_reset_n = 1'b1;
        wait_n(8);
        chk({7'h00, srst}, 8'h01);
        // Clock enable low must freeze the whole pin pipeline
        ce = 1'b0;
        bus_ack_n = 1'b0;
        wait_n(8);
        chk({7'h00, ack_m}, 8'h00);
        ce = 1'b1;
        wait_n(8);
        chk({7'h00, ack_m}, 8'h01);
        bus_ack_n = 1'b1;
    endtask : scen_bus_reset

    initial begin
        {mclk, rstn, errors, checks_done, cycles} = '0;
        {ce, bus_clk, bus_reset_n, bus_start_n, bus_ack_n} = 5'h1F;
        bus_tm_n = 2'h3;
        {inv_addr_bit_zero, inv_addr_bit_one, arb_won, arb_lost, card_selected} = 5'h00;
        early_grant = 1'b0;
        wait_n(3);
        rstn = 1'b1;
        wait_n(8);
        chk({7'h00, srst}, 8'h01);
        scen_decode();
        scen_master();
        scen_slave();
        scen_bus_reset();
        complete_run();
    end
endmodule : backplane_status_byte_decode_bench
